// file: design/ipdc_ctrl.v
// Idle and power-down sequencer for the microcontroller core
`timescale 1ns/10ps
`include "ipdc_defs.vh"
module ipdc_ctrl (
   input  wire       mclk_i,
   input  wire       rst_b_i,
   // Control register write from the core (bit layout in the header)
   input  wire       ctrl_wr_i,
   input  wire [3:0] ctrl_wdata_i,
   input  wire       instr_done_i,
   // Interrupt controller side
   input  wire       irq_pending_i,
   input  wire       irq_vector_i,
   input  wire       ext0_en_i,
   input  wire       ext1_en_i,
   input  wire       ext1_high_prio_i,
   input  wire       kbd_en_i,
   input  wire       kbd_irq_i,
   input  wire       usb_en_i,
   input  wire       usb_irq_i,
   // External interrupt pins, asynchronous while the oscillator restarts
   input  wire       external_irq_zero_i,
   input  wire       external_irq_one_i,
   // Port and strobe values from normal operation
   input  wire [7:0] port_out_i,
   input  wire       addr_latch_run_i,
   input  wire       program_store_strobe_run_i,
   output wire [3:0] ctrl_rdata_o,
   output wire       idle_request_bit_o,
   output wire       powerdown_request_bit_o,
   output wire       user_flag_zero_o,
   output wire       user_flag_one_o,
   output wire       cpu_clk_en_o,
   output wire       periph_clk_en_o,
   output wire       osc_en_o,
   output reg  [7:0] port_hold_o,
   output reg        addr_latch_o,
   output reg        program_store_strobe_o,
   output reg        wake_vector_o,
   output reg        wake_ext1_o,
   output wire       in_idle_o,
   output wire       in_powerdown_o
);
   // One-hot states
   localparam [4:0] ST_RUN   = 5'h01;
   localparam [4:0] ST_IDLE  = 5'h02;
   localparam [4:0] ST_PD    = 5'h04;
   localparam [4:0] ST_EXTW  = 5'h08;
   localparam [4:0] ST_KBDW  = 5'h10;

   reg  [4:0] state_r;
   reg  [4:0] state_nxt;
   reg  [3:0] ctrl_r;
   reg  [3:0] ctrl_nxt;
   reg        ext1_win_r;
   reg        ext1_win_nxt;
   wire       ext0_lvl;
   wire       ext1_lvl;
   wire [1:0] ext_pin;
   wire [1:0] ext_lvl;
   wire [1:0] ext_low_now;
   wire       ext_release;
   reg  [1:0] held_r;
   reg  [1:0] held_nxt;
   genvar     g;
   wire       kbd_busy;
   wire       kbd_done;
   wire       ext_low;
   wire       ext_wake_src;
   wire       kbd_start;

   // Pins can toggle while the oscillator is stopped, so resample them
   assign ext_pin = {external_irq_one_i, external_irq_zero_i};
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_pin
         ipdc_sync u_sync (
            .mclk_i    (mclk_i),
            .rst_b_i   (rst_b_i),
            .async_i   (ext_pin[g]),
            .rst_val_i (`IPDC_PIN_RESET),
            .level_o   (ext_lvl[g])
         );
      end
   endgenerate
   assign ext0_lvl = ext_lvl[0];
   assign ext1_lvl = ext_lvl[1];

   // Only enabled external pins count as wake sources
   assign ext_low_now  = {ext1_en_i & ~ext1_lvl, ext0_en_i & ~ext0_lvl};
   assign ext_low      = |ext_low_now;
   // First pin that held the wake and is high again ends it; a USB-only wake ends at once
   assign ext_release  = (|(held_r & ~ext_low_now)) | ~ext_low;
   assign ext_wake_src = ext_low | (usb_en_i & usb_irq_i);
   assign kbd_start    = (state_r == ST_PD) & ~ext_wake_src & kbd_en_i & kbd_irq_i;

   ipdc_kbd_delay u_kbd (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .start_i (kbd_start),
      .abort_i (1'b0),
      .busy_o  (kbd_busy),
      .done_o  (kbd_done)
   );

   // Control bits and state sequencing
   always @* begin
      state_nxt    = state_r;
      ctrl_nxt     = ctrl_r;
      ext1_win_nxt = ext1_win_r;
      held_nxt     = held_r;
      if (ctrl_wr_i) begin
         ctrl_nxt = ctrl_wdata_i;
      end
      case (state_r)
         ST_RUN: begin
            // Entry waits for the writing instruction to retire
            if (instr_done_i && ctrl_r[`IPDC_PD_BIT]) begin
               state_nxt = ST_PD;
            end else if (instr_done_i && ctrl_r[`IPDC_IDLE_BIT]) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (irq_pending_i) begin
               ctrl_nxt[`IPDC_IDLE_BIT] = 1'b0;
               state_nxt = ST_RUN;
            end
         end
         ST_PD: begin
            if (ext_wake_src) begin
               state_nxt    = ST_EXTW;
               held_nxt     = ext_low_now;
               ext1_win_nxt = ext_low_now[1] & (ext1_high_prio_i | ~ext_low_now[0]);
            end else if (kbd_start) begin
               state_nxt = ST_KBDW;
            end
         end
         ST_EXTW: begin
            // Oscillator runs; exit completes at first release
            held_nxt = held_r | ext_low_now;
            if (ext_release) begin
               held_nxt = 2'b00;
               ctrl_nxt[`IPDC_PD_BIT]   = 1'b0;
               ctrl_nxt[`IPDC_IDLE_BIT] = 1'b0;
               state_nxt = ST_RUN;
            end
         end
         ST_KBDW: begin
            if (kbd_done) begin
               ctrl_nxt[`IPDC_PD_BIT]   = 1'b0;
               ctrl_nxt[`IPDC_IDLE_BIT] = 1'b0;
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   // Synchronous reset returns to ST_RUN and clears the rest; registers otherwise kept
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         state_r    <= ST_RUN;
         ctrl_r     <= `IPDC_CTRL_RESET;
         ext1_win_r <= 1'b0;
         held_r     <= 2'b00;
      end else begin
         state_r    <= state_nxt;
         ctrl_r     <= ctrl_nxt;
         ext1_win_r <= ext1_win_nxt;
         held_r     <= held_nxt;
      end
   end

   // Wake vector pulse tells the core which routine to run
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         wake_vector_o <= 1'b0;
         wake_ext1_o   <= 1'b0;
      end else begin
         wake_vector_o <= ((state_r == ST_EXTW) & ext_release) | ((state_r == ST_KBDW) & kbd_done) |
                          ((state_r == ST_IDLE) & irq_pending_i);
         wake_ext1_o   <= (state_r == ST_EXTW) & ext_release & ext1_win_r;
      end
   end

   // Pins freeze at entry; strobes high in idle, low in power-down
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         port_hold_o            <= `IPDC_PORT_RESET;
         addr_latch_o           <= 1'b1;
         program_store_strobe_o <= 1'b1;
      end else if (state_r == ST_RUN) begin
         port_hold_o            <= port_out_i;
         addr_latch_o           <= (state_nxt == ST_IDLE) | ((state_nxt == ST_RUN) & addr_latch_run_i);
         program_store_strobe_o <= (state_nxt == ST_IDLE) | ((state_nxt == ST_RUN) & program_store_strobe_run_i);
      end else if (state_r == ST_IDLE) begin
         addr_latch_o           <= 1'b1;
         program_store_strobe_o <= 1'b1;
      end else begin
         addr_latch_o           <= 1'b0;
         program_store_strobe_o <= 1'b0;
      end
   end

   // CPU clock gated in every low-power state; irq logic still ticks in idle
   assign cpu_clk_en_o    = (state_r == ST_RUN);
   assign periph_clk_en_o = (state_r == ST_RUN) | (state_r == ST_IDLE);
   assign osc_en_o        = (state_r != ST_PD);

   assign ctrl_rdata_o            = ctrl_r;
   assign idle_request_bit_o      = ctrl_r[`IPDC_IDLE_BIT];
   assign powerdown_request_bit_o = ctrl_r[`IPDC_PD_BIT];
   assign user_flag_zero_o        = ctrl_r[`IPDC_FLAG0_BIT];
   assign user_flag_one_o         = ctrl_r[`IPDC_FLAG1_BIT];
   assign in_idle_o               = (state_r == ST_IDLE);
   assign in_powerdown_o          = ~cpu_clk_en_o & ~in_idle_o;
endmodule

// file: design/ipdc_defs.vh
// Constants and overview for the idle and power-down control block
// Overview of operation
// - Idle begins after the requesting instruction completes.
// - Idle gates the CPU clock only.
// - CPU state is frozen during idle.
// - Pins held, address latch and strobe high.
// - Enabled interrupt clears idle bit, gets serviced.
// - Resume after the idle instruction.
// - Power-down stops oscillator after requesting instruction.
// - RAM and registers kept through power-down.
// - Power-down ends by reset or interrupt.
// - Only two external, keyboard, USB interrupts wake.
// - Keyboard wake takes 1024 clocks.
// - External low restarts oscillator, high completes exit.
// - Either low restarts; first release completes.
// - Simultaneous external wake serves higher priority.
// - Resume after the power-down instruction.
// - Power-down bit set enters, reset clears it.
// - Reset exit reinitialises registers, interrupt does not.
// - Both bits set: power-down wins, both cleared.
`ifndef IPDC_DEFS_VH
`define IPDC_DEFS_VH
`define IPDC_IDLE_BIT        0
`define IPDC_PD_BIT          1
`define IPDC_FLAG0_BIT       2
`define IPDC_FLAG1_BIT       3
`define IPDC_CTRL_RESET      4'h0
`define IPDC_PORT_RESET      8'hFF
`define IPDC_PIN_RESET       1'b1
`define IPDC_KBD_WAKE_CLKS   1024
`define IPDC_KBD_CNT_W       11
`define IPDC_KBD_CNT_LAST    11'h3FF
`define IPDC_STRETCH_CNT_W   4
`endif

// file: design/ipdc_sync.v
// Three-stage input synchroniser with second/third stage agreement
`timescale 1ns/10ps
module ipdc_sync (
   input  wire mclk_i,
   input  wire rst_b_i,
   input  wire async_i,
   input  wire rst_val_i,
   output reg  level_o
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   // First stage feeds only the second; output moves when stages 2 and 3 agree
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         s1_r    <= rst_val_i; // Idle level of the pin, so no false edge after reset
         s2_r    <= rst_val_i;
         s3_r    <= rst_val_i;
         level_o <= rst_val_i;
      end else begin
         s1_r <= async_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_o <= s3_r;
         end
      end
   end
endmodule

// file: design/ipdc_kbd_delay.v
// Keyboard wake settling counter
`timescale 1ns/10ps
`include "ipdc_defs.vh"
module ipdc_kbd_delay (
   input  wire mclk_i,
   input  wire rst_b_i,
   input  wire start_i,
   input  wire abort_i,
   output reg  busy_o,
   output reg  done_o
);
   reg [`IPDC_KBD_CNT_W-1:0] cnt_r;
   // Counts 1024 clocks then pulses done for one cycle
   always @(posedge mclk_i) begin
      if (!rst_b_i || abort_i) begin
         cnt_r  <= {`IPDC_KBD_CNT_W{1'b0}};
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (busy_o) begin
            if (cnt_r == `IPDC_KBD_CNT_LAST) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
               cnt_r  <= {`IPDC_KBD_CNT_W{1'b0}};
            end else begin
               cnt_r <= cnt_r + 11'h001;
            end
         end else if (start_i) begin
            busy_o <= 1'b1;
            cnt_r  <= {`IPDC_KBD_CNT_W{1'b0}};
         end
      end
   end
endmodule

// file: dv/ipdc_chk.sv
// Port checker for the idle and power-down sequencer
`timescale 1ns/10ps
module ipdc_chk (
   input wire       mclk_i,
   input wire       rst_b_i,
   input wire       instr_done_i,
   input wire       irq_pending_i,
   input wire [3:0] ctrl_rdata_o,
   input wire       idle_request_bit_o,
   input wire       powerdown_request_bit_o,
   input wire       cpu_clk_en_o,
   input wire       periph_clk_en_o,
   input wire       osc_en_o,
   input wire [7:0] port_hold_o,
   input wire       addr_latch_o,
   input wire       program_store_strobe_o,
   input wire       wake_vector_o,
   input wire       wake_ext1_o,
   input wire       in_idle_o,
   input wire       in_powerdown_o
);
   // One clock domain, so one clocking and one disable
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   idle_clocks_a: assert property (in_idle_o |-> !cpu_clk_en_o && periph_clk_en_o && osc_en_o)
      else $error("idle clock enables wrong");
   // Entry edge excluded: the hold register loads there
   idle_pins_a: assert property (in_idle_o && $past(in_idle_o) |-> $stable(port_hold_o)
      && addr_latch_o && program_store_strobe_o) else $error("idle pins moved");
   idle_entry_a: assert property (!in_idle_o && !in_powerdown_o && instr_done_i && idle_request_bit_o
      && !powerdown_request_bit_o && !irq_pending_i |=> in_idle_o) else $error("idle not entered");
   idle_exit_a: assert property (in_idle_o && irq_pending_i |=> !in_idle_o && !idle_request_bit_o
      && wake_vector_o) else $error("idle not left");
   pd_entry_a: assert property (!in_idle_o && !in_powerdown_o && instr_done_i && powerdown_request_bit_o
      |=> in_powerdown_o && !osc_en_o && !in_idle_o) else $error("power-down not entered");
   osc_stop_a: assert property (!osc_en_o |-> in_powerdown_o && !cpu_clk_en_o)
      else $error("oscillator stopped outside power-down");
   pd_retain_a: assert property (in_powerdown_o && $past(in_powerdown_o) |-> $stable(ctrl_rdata_o))
      else $error("control bits changed in power-down");
   wake_clear_a: assert property (wake_vector_o |-> !in_powerdown_o && !in_idle_o
      && !powerdown_request_bit_o && !idle_request_bit_o) else $error("wake left bits set");
   ext1_pick_a: assert property (wake_ext1_o |-> wake_vector_o)
      else $error("ext1 choice without wake");
endmodule
bind ipdc_ctrl ipdc_chk chk_u (.mclk_i, .rst_b_i, .instr_done_i, .irq_pending_i, .ctrl_rdata_o,
   .idle_request_bit_o, .powerdown_request_bit_o, .cpu_clk_en_o, .periph_clk_en_o, .osc_en_o, .port_hold_o,
   .addr_latch_o, .program_store_strobe_o, .wake_vector_o, .wake_ext1_o, .in_idle_o, .in_powerdown_o);

// file: dv/test_idle_powerdown_control.sv
// Self-checking bench for the idle and power-down sequencer
`timescale 1ns/10ps
module test_idle_powerdown_control;
   reg        mclk_i = 1'b0, rst_b_i = 1'b0, ctrl_wr_i = 1'b0, instr_done_i = 1'b0, irq_pending_i = 1'b0;
   reg        irq_vector_i = 1'b0, ext0_en_i = 1'b0, ext1_en_i = 1'b0, ext1_high_prio_i = 1'b0;
   reg        kbd_en_i = 1'b0, kbd_irq_i = 1'b0, usb_en_i = 1'b0, usb_irq_i = 1'b0;
   reg        external_irq_zero_i = 1'b1, external_irq_one_i = 1'b1;
   reg        addr_latch_run_i = 1'b0, program_store_strobe_run_i = 1'b0;
   reg  [3:0] ctrl_wdata_i = 4'h0;
   reg  [7:0] port_out_i = 8'h00, port_v, exp_v;
   wire [3:0] ctrl_rdata_o;
   wire [7:0] port_hold_o;
   wire       idle_request_bit_o, powerdown_request_bit_o, user_flag_zero_o, user_flag_one_o, cpu_clk_en_o;
   wire       periph_clk_en_o, osc_en_o, addr_latch_o, program_store_strobe_o, wake_vector_o, wake_ext1_o;
   wire       in_idle_o, in_powerdown_o;
   integer    mismatches = 0, n_tests = 0, cycles = 0, cyc, i, rnd;
   ipdc_ctrl dut_u (.mclk_i, .rst_b_i, .ctrl_wr_i, .ctrl_wdata_i, .instr_done_i, .irq_pending_i, .irq_vector_i,
      .ext0_en_i, .ext1_en_i, .ext1_high_prio_i, .kbd_en_i, .kbd_irq_i, .usb_en_i, .usb_irq_i,
      .external_irq_zero_i, .external_irq_one_i, .port_out_i, .addr_latch_run_i, .program_store_strobe_run_i,
      .ctrl_rdata_o, .idle_request_bit_o, .powerdown_request_bit_o, .user_flag_zero_o, .user_flag_one_o,
      .cpu_clk_en_o, .periph_clk_en_o, .osc_en_o, .port_hold_o, .addr_latch_o, .program_store_strobe_o,
      .wake_vector_o, .wake_ext1_o, .in_idle_o, .in_powerdown_o);
   // 250 MHz clock and a cycle ceiling against hangs
   always #2 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         give_verdict;
      end
   end
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Write the request bits, then retire the requesting instruction
   task req(input [3:0] bits);
      begin
         @(posedge mclk_i);
         ctrl_wr_i <= 1'b1;
         ctrl_wdata_i <= bits;
         @(posedge mclk_i);
         ctrl_wr_i <= 1'b0;
         instr_done_i <= 1'b1;
         @(posedge mclk_i);
         instr_done_i <= 1'b0;
         @(negedge mclk_i);
      end
   endtask
   // Bounded wait on the wake pulse, sampled mid-cycle
   task wait_vec;
      begin
         cyc = 0;
         while (wake_vector_o !== 1'b1 && cyc < 2000) begin
            @(negedge mclk_i);
            cyc = cyc + 1;
         end
      end
   endtask
   // Wake clears both request bits and keeps the user flags
   function [3:0] after_wake(input [3:0] bits);
      begin
         after_wake = {bits[3:2], 2'b00};
      end
   endfunction
   task give_verdict;
      begin
         $display("tests=%0d mismatches=%0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      rnd = $urandom(32'hE5A2);
      // Three reset edges initialise every flop, synchronisers included (they load the pin idle level)
      repeat (3) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      @(negedge mclk_i);
      chk({ctrl_rdata_o, cpu_clk_en_o, periph_clk_en_o, osc_en_o, program_store_strobe_o}, 8'h0F);
      // Idle with every user flag pattern and a random port value
      for (i = 0; i < 4; i = i + 1) begin
         port_v = $urandom;
         @(posedge mclk_i);
         port_out_i <= port_v;
         addr_latch_run_i <= $urandom;
         req({i[1:0], 2'b01});
         chk({in_idle_o, cpu_clk_en_o, periph_clk_en_o, osc_en_o}, 8'h0B);
         exp_v = {6'h03, i[1:0]};
         chk({addr_latch_o, program_store_strobe_o, user_flag_one_o, user_flag_zero_o}, exp_v);
         @(posedge mclk_i);
         port_out_i <= ~port_v;
         repeat (3) @(posedge mclk_i);
         chk(port_hold_o, port_v);
         irq_pending_i <= 1'b1;
         @(posedge mclk_i);
         irq_pending_i <= 1'b0;
         @(negedge mclk_i);
         exp_v = {4'hA, after_wake({i[1:0], 2'b01})};
         chk({wake_vector_o, in_idle_o, cpu_clk_en_o, 1'b0, ctrl_rdata_o}, exp_v);
      end
      // Power-down left by both external pins; priority, flag, idle bit and release order varied
      @(posedge mclk_i);
      ext0_en_i <= 1'b1;
      ext1_en_i <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge mclk_i);
         ext1_high_prio_i <= i[0];
         req({i[0], 2'b01, i[1]});
         chk({in_powerdown_o, osc_en_o, cpu_clk_en_o, in_idle_o}, 8'h08);
         chk({powerdown_request_bit_o, idle_request_bit_o}, {7'h01, i[1]});
         @(posedge mclk_i);
         external_irq_zero_i <= 1'b0;
         external_irq_one_i <= 1'b0;
         repeat (7) @(posedge mclk_i);
         @(negedge mclk_i);
         chk({osc_en_o, in_powerdown_o}, 8'h03);
         // Half the runs keep the second pin low: the first release must end the wake
         @(posedge mclk_i);
         external_irq_zero_i <= 1'b1;
         external_irq_one_i <= i[1];
         wait_vec;
         exp_v = {2'b00, i[0], 1'b0, after_wake({i[0], 2'b01, i[1]})};
         chk({wake_ext1_o, in_powerdown_o, ctrl_rdata_o}, exp_v);
         @(posedge mclk_i);
         external_irq_one_i <= 1'b1;
         repeat (4) @(posedge mclk_i);
      end
      // Keyboard wake takes the long settling count
      @(posedge mclk_i);
      ext0_en_i <= 1'b0;
      ext1_en_i <= 1'b0;
      kbd_en_i <= 1'b1;
      req(4'h2);
      @(posedge mclk_i);
      kbd_irq_i <= 1'b1;
      wait_vec;
      chk(cyc >= 1024 && cyc <= 1028, 8'h01);
      // Idle with a flag set, ended by a reset of two machine cycles
      @(posedge mclk_i);
      kbd_irq_i <= 1'b0;
      kbd_en_i <= 1'b0;
      req(4'h5);
      chk({in_idle_o, user_flag_zero_o}, 8'h03);
      @(posedge mclk_i);
      rst_b_i <= 1'b0;
      repeat (24) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      @(negedge mclk_i);
      chk({in_idle_o, cpu_clk_en_o, ctrl_rdata_o}, 8'h10);
      chk(port_hold_o, 8'hFF);
      // Disabled sources must not wake; only reset ends it
      req(4'h2);
      @(posedge mclk_i);
      usb_irq_i <= 1'b1;
      kbd_irq_i <= 1'b1;
      external_irq_zero_i <= 1'b0;
      irq_pending_i <= 1'b1;
      repeat (20) @(posedge mclk_i);
      @(negedge mclk_i);
      chk({in_powerdown_o, osc_en_o}, 8'h02);
      @(posedge mclk_i);
      rst_b_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      @(negedge mclk_i);
      chk({in_powerdown_o, osc_en_o, ctrl_rdata_o}, 8'h10);
      give_verdict;
   end
endmodule
